// ### src/psgn_consts.svh
// Register offsets, field positions and reset values of the sign and configuration bank
`ifndef PSGN_CONSTS_SVH
`define PSGN_CONSTS_SVH
`define PSGN_ADDR_W 16
`define PSGN_OFF_SIGN 16'he617
`define PSGN_OFF_CFG 16'he618
`define PSGN_SIGN_RST 16'h0000
`define PSGN_CFG_RST 16'h0010
`define PSGN_CFG_WMASK 16'h003b
`define PSGN_BIT_ASIGN 0
`define PSGN_BIT_SUM1 3
`define PSGN_BIT_RSIGN 4
`define PSGN_BIT_SUM2 7
`define PSGN_BIT_SUM3 8
`define PSGN_CFG_PIN_LO 0
`define PSGN_CFG_SWAP 3
`define PSGN_CFG_HPF 4
`define PSGN_CFG_LPF 5
`define PSGN_SETTLE_SHORT_MS 650
`define PSGN_SETTLE_LONG_MS 1300
`endif

// ### src/psgn_pkg.sv
// Types shared by the sign and configuration bank
package psgn_pkg;
  typedef enum logic [1:0]
  {
    PSGN_PIN_READY = 2'b00,
    PSGN_PIN_ZX_A = 2'b01,
    PSGN_PIN_ZX_B = 2'b10,
    PSGN_PIN_ZX_C = 2'b11
  } psgn_pin_sel_t;
endpackage

// ### src/psgn_path_sum.sv
// Signed sum of selected phase powers for one pulse-output datapath
`timescale 1ns/10ps
module psgn_path_sum #(
  parameter int PW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Phase powers of the type chosen for this path
  input wire logic signed [PW-1:0] pwr_a,
  input wire logic signed [PW-1:0] pwr_b,
  input wire logic signed [PW-1:0] pwr_c,
  input wire logic [2:0] phase_select,
  // Result
  output logic sum_negative
);
  if (PW < 2)
  begin : g_bad_pw
    $error("psgn_path_sum: PW must be at least 2");
  end

  logic signed [PW+1:0] sum_nxt;

  always_comb
  begin
    sum_nxt = '0;
    if (phase_select[0])
      sum_nxt = sum_nxt + (PW+2)'(pwr_a);
    if (phase_select[1])
      sum_nxt = sum_nxt + (PW+2)'(pwr_b);
    if (phase_select[2])
      sum_nxt = sum_nxt + (PW+2)'(pwr_c);
  end

  // Extra two bits keep three-way sums from wrapping
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sum_negative <= 1'b0;
    else
      sum_negative <= sum_nxt[PW+1];
  end
endmodule // psgn_path_sum

// ### src/psgn_regs.sv
// Power sign flags and general configuration register bank
// What this block does
// - Sign bits 0..2 show phase A/B/C active power negative, total or fundamental.
// - Sign bits 4..6 show phase A/B/C reactive power negative, total or fundamental.
// - Sign bit 3 shows the first pulse path sum negative.
// - Sign bit 7 shows the second pulse path sum negative.
// - Sign bit 8 shows the third pulse path sum negative.
// - Sign bits 15..9 always read zero.
// - Configuration bit 2 always reads zero and does nothing.
// - Config bits 1:0 pick sample-ready or zero-crossing A/B/C for the indicator pin.
// - Config bit 3 swaps voltage and current channel outputs of A, B, C, N.
// - Config bit 4, reset 1, enables all high-pass filters.
// - Config bit 5 chooses active-power low-pass settling time.
// - Settling is 650 ms when clear, 1300 ms when set.
`include "psgn_consts.svh"
`timescale 1ns/10ps
module psgn_regs
  import psgn_pkg::*;
#(
  parameter int PW = 32,
  parameter int SW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [`PSGN_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Power source selects and path selects
  input wire logic active_power_source_select,
  input wire logic reactive_power_source_select,
  input wire logic [2:0] path1_phase_select,
  input wire logic [2:0] path2_phase_select,
  input wire logic [2:0] path3_phase_select,
  input wire logic [2:0] path1_power_type,
  input wire logic [2:0] path2_power_type,
  input wire logic [2:0] path3_power_type,
  // Per-phase powers: total and fundamental active, reactive, apparent
  input wire logic signed [PW-1:0] act_tot_a,
  input wire logic signed [PW-1:0] act_tot_b,
  input wire logic signed [PW-1:0] act_tot_c,
  input wire logic signed [PW-1:0] act_fun_a,
  input wire logic signed [PW-1:0] act_fun_b,
  input wire logic signed [PW-1:0] act_fun_c,
  input wire logic signed [PW-1:0] rea_tot_a,
  input wire logic signed [PW-1:0] rea_tot_b,
  input wire logic signed [PW-1:0] rea_tot_c,
  input wire logic signed [PW-1:0] rea_fun_a,
  input wire logic signed [PW-1:0] rea_fun_b,
  input wire logic signed [PW-1:0] rea_fun_c,
  input wire logic signed [PW-1:0] app_a,
  input wire logic signed [PW-1:0] app_b,
  input wire logic signed [PW-1:0] app_c,
  // Indicator pin sources
  input wire logic sample_ready_signal,
  input wire logic [2:0] zero_crossing_signal,
  output logic indicator_pin,
  // Channel samples in and out
  input wire logic [SW-1:0] v_in_a,
  input wire logic [SW-1:0] v_in_b,
  input wire logic [SW-1:0] v_in_c,
  input wire logic [SW-1:0] v_in_n,
  input wire logic [SW-1:0] i_in_a,
  input wire logic [SW-1:0] i_in_b,
  input wire logic [SW-1:0] i_in_c,
  input wire logic [SW-1:0] i_in_n,
  output logic [SW-1:0] v_out_a,
  output logic [SW-1:0] v_out_b,
  output logic [SW-1:0] v_out_c,
  output logic [SW-1:0] v_out_n,
  output logic [SW-1:0] i_out_a,
  output logic [SW-1:0] i_out_b,
  output logic [SW-1:0] i_out_c,
  output logic [SW-1:0] i_out_n,
  // Filter controls
  output logic highpass_enable,
  output logic lowpass_settling_select,
  output logic [10:0] lowpass_settling_ms
);
  // Elaboration stops on widths the sign taps cannot serve
  if (PW < 2 || SW < 1)
  begin : g_bad_param
    $error("psgn_regs: PW must be at least 2 and SW at least 1");
  end

  logic [15:0] cfg_r;
  logic [8:0] sign_r;
  logic [8:0] sign_nxt;
  logic [2:0] sum_neg;
  logic signed [PW-1:0] act_sel [3];
  logic signed [PW-1:0] rea_sel [3];
  logic signed [PW-1:0] path_pwr [3][3];
  logic [2:0] path_type [3];
  logic [2:0] path_phase [3];
  psgn_pin_sel_t pin_sel;

  always_comb
  begin
    // Source selects pick total or fundamental
    act_sel[0] = active_power_source_select ? act_fun_a : act_tot_a;
    act_sel[1] = active_power_source_select ? act_fun_b : act_tot_b;
    act_sel[2] = active_power_source_select ? act_fun_c : act_tot_c;
    rea_sel[0] = reactive_power_source_select ? rea_fun_a : rea_tot_a;
    rea_sel[1] = reactive_power_source_select ? rea_fun_b : rea_tot_b;
    rea_sel[2] = reactive_power_source_select ? rea_fun_c : rea_tot_c;
  end

  assign path_type[0] = path1_power_type;
  assign path_type[1] = path2_power_type;
  assign path_type[2] = path3_power_type;
  assign path_phase[0] = path1_phase_select;
  assign path_phase[1] = path2_phase_select;
  assign path_phase[2] = path3_phase_select;

  // Reserved power types feed zero, so such a path reads positive
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      unique case (path_type[p])
        3'h0:
        begin
          path_pwr[p][0] = act_tot_a;
          path_pwr[p][1] = act_tot_b;
          path_pwr[p][2] = act_tot_c;
        end
        3'h1:
        begin
          path_pwr[p][0] = rea_tot_a;
          path_pwr[p][1] = rea_tot_b;
          path_pwr[p][2] = rea_tot_c;
        end
        3'h2:
        begin
          path_pwr[p][0] = app_a;
          path_pwr[p][1] = app_b;
          path_pwr[p][2] = app_c;
        end
        3'h3:
        begin
          path_pwr[p][0] = act_fun_a;
          path_pwr[p][1] = act_fun_b;
          path_pwr[p][2] = act_fun_c;
        end
        3'h4:
        begin
          path_pwr[p][0] = rea_fun_a;
          path_pwr[p][1] = rea_fun_b;
          path_pwr[p][2] = rea_fun_c;
        end
        default:
        begin
          path_pwr[p][0] = '0;
          path_pwr[p][1] = '0;
          path_pwr[p][2] = '0;
        end
      endcase
    end
  end

  // One summer per pulse datapath
  for (genvar g = 0; g < 3; g++)
  begin : g_path
    psgn_path_sum #(
      .PW(PW)
    ) u_sum (
      .clk(clk),
      .rst_n(rst_n),
      .pwr_a(path_pwr[g][0]),
      .pwr_b(path_pwr[g][1]),
      .pwr_c(path_pwr[g][2]),
      .phase_select(path_phase[g]),
      .sum_negative(sum_neg[g])
    );
  end

  always_comb
  begin
    sign_nxt = '0;
    for (int k = 0; k < 3; k++)
    begin
      sign_nxt[`PSGN_BIT_ASIGN + k] = act_sel[k][PW-1];
      sign_nxt[`PSGN_BIT_RSIGN + k] = rea_sel[k][PW-1];
    end
    sign_nxt[`PSGN_BIT_SUM1] = sum_neg[0];
    sign_nxt[`PSGN_BIT_SUM2] = sum_neg[1];
    sign_nxt[`PSGN_BIT_SUM3] = sum_neg[2];
  end

  // Hardware owns every sign bit; the bus cannot reach them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sign_r <= 9'(`PSGN_SIGN_RST);
    else
      sign_r <= sign_nxt;
  end

  // Only the in-scope bits are writable; bit 2 stays zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_r <= `PSGN_CFG_RST;
    else if (reg_wr && reg_addr == `PSGN_OFF_CFG)
      cfg_r <= reg_wdata & `PSGN_CFG_WMASK;
  end

  // Unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd && reg_addr == `PSGN_OFF_SIGN)
      reg_rdata <= {7'h00, sign_r};
    else if (reg_rd && reg_addr == `PSGN_OFF_CFG)
      reg_rdata <= cfg_r;
    else
      reg_rdata <= 16'h0000;
  end

  assign pin_sel = psgn_pin_sel_t'(cfg_r[`PSGN_CFG_PIN_LO +: 2]);

  always_comb
  begin
    unique case (pin_sel)
      PSGN_PIN_READY: indicator_pin = sample_ready_signal;
      PSGN_PIN_ZX_A: indicator_pin = zero_crossing_signal[0];
      PSGN_PIN_ZX_B: indicator_pin = zero_crossing_signal[1];
      PSGN_PIN_ZX_C: indicator_pin = zero_crossing_signal[2];
    endcase
  end

  // Registered so channel data stays a flop output; both paths take one cycle, swapped or not
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      v_out_a <= '0;
      v_out_b <= '0;
      v_out_c <= '0;
      v_out_n <= '0;
      i_out_a <= '0;
      i_out_b <= '0;
      i_out_c <= '0;
      i_out_n <= '0;
    end
    else if (cfg_r[`PSGN_CFG_SWAP])
    begin
      v_out_a <= i_in_a;
      v_out_b <= i_in_b;
      v_out_c <= i_in_c;
      v_out_n <= i_in_n;
      i_out_a <= v_in_a;
      i_out_b <= v_in_b;
      i_out_c <= v_in_c;
      i_out_n <= v_in_n;
    end
    else
    begin
      v_out_a <= v_in_a;
      v_out_b <= v_in_b;
      v_out_c <= v_in_c;
      v_out_n <= v_in_n;
      i_out_a <= i_in_a;
      i_out_b <= i_in_b;
      i_out_c <= i_in_c;
      i_out_n <= i_in_n;
    end
  end

  assign highpass_enable = cfg_r[`PSGN_CFG_HPF];
  assign lowpass_settling_select = cfg_r[`PSGN_CFG_LPF];
  assign lowpass_settling_ms = cfg_r[`PSGN_CFG_LPF] ? 11'(`PSGN_SETTLE_LONG_MS) : 11'(`PSGN_SETTLE_SHORT_MS);

  a_sign_ro: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `PSGN_OFF_SIGN |=> sign_r == $past(sign_nxt))
    else $error("sign register changed by host write");
  a_sign_upper: assert property (@(posedge clk) disable iff (!rst_n)
    $past(reg_rd) && $past(reg_addr) == `PSGN_OFF_SIGN |-> reg_rdata[15:9] == 7'h00)
    else $error("sign upper bits not zero");
  a_act_sign: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 sign_r[0] == $past(active_power_source_select ? act_fun_a[PW-1] : act_tot_a[PW-1]))
    else $error("phase A active sign wrong");
  a_rea_sign: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 sign_r[6] == $past(reactive_power_source_select ? rea_fun_c[PW-1] : rea_tot_c[PW-1]))
    else $error("phase C reactive sign wrong");
  a_sum1_sign: assert property (@(posedge clk) disable iff (!rst_n)
    path1_power_type == 3'h0 && path1_phase_select == 3'b001 |=> ##1 sign_r[3] == $past(act_tot_a[PW-1], 2))
    else $error("path 1 sum sign wrong");
  a_sum2_sign: assert property (@(posedge clk) disable iff (!rst_n)
    path2_phase_select == 3'b000 |=> ##1 !sign_r[7])
    else $error("empty path 2 sum not positive");
  a_sum3_sign: assert property (@(posedge clk) disable iff (!rst_n)
    path3_power_type == 3'h2 && path3_phase_select == 3'b100 |=> ##1 sign_r[8] == $past(app_c[PW-1], 2))
    else $error("path 3 sum sign wrong");
  a_cfg_bit2: assert property (@(posedge clk) disable iff (!rst_n)
    $past(reg_rd) && $past(reg_addr) == `PSGN_OFF_CFG |-> !reg_rdata[2])
    else $error("config bit 2 not zero");
  a_pin_route: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_r[1:0] == 2'b10 |-> indicator_pin == zero_crossing_signal[1])
    else $error("indicator pin source wrong");
  a_swap_path: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_r[3] |=> v_out_b == $past(i_in_b) && i_out_n == $past(v_in_n))
    else $error("channel swap wrong");
  a_hpf_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `PSGN_OFF_CFG |=> highpass_enable == $past(reg_wdata[4]))
    else $error("high-pass enable not written");
  a_lpf_time: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `PSGN_OFF_CFG |=> lowpass_settling_ms == ($past(reg_wdata[5]) ? 11'd1300 : 11'd650))
    else $error("settling time wrong");
  c_swap_on: cover property (@(posedge clk) disable iff (!rst_n) reg_wr && reg_addr == `PSGN_OFF_CFG && reg_wdata[3]);
  c_sign_read: cover property (@(posedge clk) disable iff (!rst_n) reg_rd && reg_addr == `PSGN_OFF_SIGN && sign_r != 9'h000);
  c_zx_c: cover property (@(posedge clk) disable iff (!rst_n) pin_sel == PSGN_PIN_ZX_C);
endmodule // psgn_regs

// ### bench/psgn_regs_tb.sv
// Self-checking bench for the power sign and configuration bank
`timescale 1ns/10ps
`include "psgn_consts.svh"
module psgn_regs_tb;
  logic clk, rst_n, reg_wr, reg_rd, aps, rps, srdy, ind, hpf, lps;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0] zx;
  logic [2:0] ps[3];
  logic [2:0] pt[3];
  logic signed [31:0] at[3], af[3], rt[3], rf[3], ap[3];
  logic [23:0] vi[4], ii[4], vo[4], io[4];
  logic [10:0] lms;
  int failures = 0;
  int checks = 0;

  psgn_regs #(.PW(32), .SW(24)) DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .active_power_source_select(aps), .reactive_power_source_select(rps),
    .path1_phase_select(ps[0]), .path2_phase_select(ps[1]), .path3_phase_select(ps[2]),
    .path1_power_type(pt[0]), .path2_power_type(pt[1]), .path3_power_type(pt[2]),
    .act_tot_a(at[0]), .act_tot_b(at[1]), .act_tot_c(at[2]), .act_fun_a(af[0]), .act_fun_b(af[1]),
    .act_fun_c(af[2]), .rea_tot_a(rt[0]), .rea_tot_b(rt[1]), .rea_tot_c(rt[2]), .rea_fun_a(rf[0]),
    .rea_fun_b(rf[1]), .rea_fun_c(rf[2]), .app_a(ap[0]), .app_b(ap[1]), .app_c(ap[2]),
    .sample_ready_signal(srdy), .zero_crossing_signal(zx), .indicator_pin(ind),
    .v_in_a(vi[0]), .v_in_b(vi[1]), .v_in_c(vi[2]), .v_in_n(vi[3]),
    .i_in_a(ii[0]), .i_in_b(ii[1]), .i_in_c(ii[2]), .i_in_n(ii[3]),
    .v_out_a(vo[0]), .v_out_b(vo[1]), .v_out_c(vo[2]), .v_out_n(vo[3]),
    .i_out_a(io[0]), .i_out_b(io[1]), .i_out_c(io[2]), .i_out_n(io[3]),
    .highpass_enable(hpf), .lowpass_settling_select(lps), .lowpass_settling_ms(lms));

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask

  // Wide sum so that large phase powers cannot wrap the sign
  function automatic logic psum(input int i);
    longint t;
    t = 0;
    for (int p = 0; p < 3; p++)
      if (ps[i][p])
        case (pt[i])
          0: t += at[p];
          1: t += rt[p];
          2: t += ap[p];
          3: t += af[p];
          4: t += rf[p];
          default: ;
        endcase
    return t < 0;
  endfunction

  function automatic logic [15:0] exp_sign();
    logic [15:0] s;
    s = '0;
    for (int p = 0; p < 3; p++)
    begin
      s[p] = (aps ? af[p] : at[p]) < 0;
      s[4+p] = (rps ? rf[p] : rt[p]) < 0;
    end
    s[3] = psum(0);
    s[7] = psum(1);
    s[8] = psum(2);
    return s;
  endfunction

  // Case k mixes signs, selects, every power type and both source selects
  // Case 8 drives full-scale three-way sums; case 9 single-phase paths 1 and 3
  task automatic setk(input int k);
    @(posedge clk);
    aps <= k[0];
    rps <= k[1];
    for (int p = 0; p < 3; p++)
    begin
      at[p] <= (k == 8) ? 32'sh80000000 : (k[p] ? -150 * (p + 1) : 100 * (p + 1));
      af[p] <= k[(p+1)%4] ? -90 : 40 * (p + 1);
      rt[p] <= k[(p+2)%4] ? -70 * (p + 1) : 60;
      rf[p] <= k[(p+3)%4] ? -50 : 30 * (p + 2);
      ap[p] <= (k == 8 || k[(p+1)%3]) ? 32'sh7fffffff : 500;
      if (k == 8 && p != 1)
      begin
        ps[p] <= 3'h7;
        pt[p] <= (p == 0) ? 3'h0 : 3'h2;
      end
      else if (k == 9 && p != 1)
      begin
        ps[p] <= (p == 0) ? 3'h1 : 3'h4;
        pt[p] <= (p == 0) ? 3'h0 : 3'h2;
      end
      else
      begin
        ps[p] <= 3'(k + p + 1);
        pt[p] <= 3'(k + 2 * p);
      end
    end
  endtask

  initial
  begin
    #400000;
    failures++;
    stop_test();
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, aps, rps, srdy, zx, reg_addr, reg_wdata} = '0;
    for (int p = 0; p < 4; p++)
    begin
      vi[p] = 24'h100000 + 24'(p);
      ii[p] = 24'h200000 + 24'(p);
    end
    for (int p = 0; p < 3; p++)
      {at[p], af[p], rt[p], rf[p], ap[p], ps[p], pt[p]} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rd(`PSGN_OFF_SIGN, d);
    chk("sign reset", 32'h0, 32'(d));
    rd(`PSGN_OFF_CFG, d);
    chk("cfg reset", 32'h10, 32'(d));
    chk("hpf reset", 32'h1, 32'(hpf));
    wr(`PSGN_OFF_CFG, 16'hffff);
    rd(`PSGN_OFF_CFG, d);
    chk("cfg mask", 32'h3b, 32'(d));
    chk("hpf on", 32'h1, 32'(hpf));
    chk("lpf set", 32'h1, 32'(lps));
    chk("settle long", 32'd1300, 32'(lms));
    wr(`PSGN_OFF_CFG, 16'h0000);
    rd(`PSGN_OFF_CFG, d);
    chk("cfg clear", 32'h0, 32'(d));
    chk("hpf off", 32'h0, 32'(hpf));
    chk("lpf clear", 32'h0, 32'(lps));
    chk("settle short", 32'd650, 32'(lms));
    rd(16'he619, d);
    chk("unmapped", 32'h0, 32'(d));
    for (int c = 0; c < 4; c++)
    begin
      wr(`PSGN_OFF_CFG, 16'(c));
      for (int j = 0; j < 2; j++)
      begin
        @(posedge clk);
        srdy <= j[0];
        // Every source gets its own two-step pattern, so a wrong route shows
        zx <= j[0] ? 3'h2 : 3'h3;
        @(negedge clk);
        chk("indicator", 32'(c == 0 ? srdy : zx[c-1]), 32'(ind));
      end
    end
    for (int s = 0; s < 2; s++)
    begin
      wr(`PSGN_OFF_CFG, s[0] ? 16'h0008 : 16'h0000);
      repeat (2) @(posedge clk);
      #1;
      for (int p = 0; p < 4; p++)
      begin
        chk("v out", 32'(s[0] ? ii[p] : vi[p]), 32'(vo[p]));
        chk("i out", 32'(s[0] ? vi[p] : ii[p]), 32'(io[p]));
      end
    end
    for (int k = 0; k < 10; k++)
    begin
      setk(k);
      // A host write to the read-only flags must not stick
      if (k == 4)
        wr(`PSGN_OFF_SIGN, 16'hffff);
      repeat (3) @(posedge clk);
      rd(`PSGN_OFF_SIGN, d);
      chk("sign", 32'(exp_sign()), 32'(d));
    end
    stop_test();
  end
endmodule // psgn_regs_tb
